// ===== src/hs_iso_transfer_descriptor.sv
`timescale 1ns/1ps
module hs_iso_transfer_descriptor
(
    // Clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    // Register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        we_i,
    input  wire logic        re_i,
    output logic [31:0]      rdata_o,
    // Bus timing from the frame counter
    input  wire logic        uframe_tick_i,
    input  wire logic [4:0]  bus_frame_i,
    input  wire logic [2:0]  uframe_idx_i,
    // Transaction request to packet engine
    output logic             txn_req_o,
    output logic             txn_split_o,
    output logic             txn_in_o,
    output logic [6:0]       txn_func_addr_o,
    output logic [3:0]       txn_ep_o,
    output logic [10:0]      txn_len_o,
    output logic [15:0]      txn_buf_o,
    // Transaction completion
    input  wire logic        txn_done_i,
    input  wire logic [10:0] txn_bytes_i,
    input  wire logic        txn_err_i,
    input  wire logic        txn_babble_i,
    input  wire logic        txn_underrun_i,
    input  wire logic        txn_stall_i,
    // Descriptor state
    output logic             td_valid_o,
    output logic             td_halt_o
);
    td_fields_if f ();

    logic [31:0]         dw0_q;
    logic [31:0]         dw1_q;
    logic [31:0]         dw2_q;
    logic [31:0]         dw3_q;
    logic [31:0]         dw4_q;
    logic [31:0]         rdata_q;
    iso_td_pkg::state_e  st_q;
    iso_td_pkg::state_e  st_d;
    logic [2:0]          uf_q;
    logic [1:0]          pkt_cnt_q;
    logic [2:0]          acc_q;
    logic [14:0]         done_bytes;
    logic [14:0]         rem;
    logic [10:0]         pkt_len;
    logic                start;
    logic                more;
    logic                fatal;
    logic                finished;
    logic [7:0]          mask_left;
    logic [2:0]          res_cur;
    logic                wr0;
    logic                wr1;
    logic                wr2;
    logic                wr3;
    logic                wr4;

    td_field_decode u_dec
    (
        .dw0_i (dw0_q),
        .dw1_i (dw1_q),
        .dw2_i (dw2_q),
        .f     (f)
    );

    assign wr0 = we_i && (addr_i == iso_td_pkg::DW0_OFS);
    assign wr1 = we_i && (addr_i == iso_td_pkg::DW1_OFS);
    assign wr2 = we_i && (addr_i == iso_td_pkg::DW2_OFS);
    assign wr3 = we_i && (addr_i == iso_td_pkg::DW3_OFS);
    assign wr4 = we_i && (addr_i == iso_td_pkg::DW4_OFS);

    ////////////////////////////////////////////////////////////////////////////
    // Scheduling decisions

    assign done_bytes = dw3_q[iso_td_pkg::DONE_LSB +: iso_td_pkg::XLEN_W];
    // Guard against a count that software set above the length
    assign rem = (done_bytes >= f.xfer_len) ? 15'h0000 : 15'(f.xfer_len - done_bytes); // RULE9
    assign pkt_len = (rem < 15'(f.maxp)) ? rem[10:0] : f.maxp; // RULE8 RULE12
    // Kind and token checked so a malformed descriptor never reaches the bus
    assign start = uframe_tick_i && dw0_q[iso_td_pkg::VALID_BIT] && !dw3_q[iso_td_pkg::HALT_BIT]
                   && f.kind_iso && f.token_ok
                   && (bus_frame_i == f.frame) && dw4_q[iso_td_pkg::MASK_LSB + 32'(uframe_idx_i)]; // RULE12 RULE13
    assign more = (pkt_cnt_q < f.mult) && (rem != 15'h0000) && dw0_q[iso_td_pkg::VALID_BIT]; // RULE7
    assign fatal = txn_done_i && (txn_err_i || txn_stall_i);
    assign mask_left = dw4_q[7:0] & ~(8'h01 << uf_q);
    assign finished = (rem == 15'h0000) || (mask_left == 8'h00);
    assign res_cur = dw4_q[iso_td_pkg::RES_LSB + 3 * 32'(uf_q) +: iso_td_pkg::RES_W];

    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            iso_td_pkg::S_IDLE:  if (start) st_d = iso_td_pkg::S_ISSUE;
            iso_td_pkg::S_ISSUE: st_d = more ? iso_td_pkg::S_WAIT : iso_td_pkg::S_CLOSE;
            iso_td_pkg::S_WAIT:  if (txn_done_i) st_d = iso_td_pkg::S_CLOSE;
            iso_td_pkg::S_CLOSE: st_d = iso_td_pkg::S_IDLE;
            default:             st_d = iso_td_pkg::S_IDLE;
        endcase
        // Successful packet goes back for the next one of the microframe
        if (st_q == iso_td_pkg::S_WAIT && txn_done_i && !fatal)
        begin
            st_d = iso_td_pkg::S_ISSUE;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            st_q <= iso_td_pkg::S_IDLE;
        end
        else if (ce_i)
        begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-microframe bookkeeping

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            uf_q      <= 3'h0;
            pkt_cnt_q <= 2'h0;
            acc_q     <= 3'h0;
        end
        else if (ce_i)
        begin
            if (st_q == iso_td_pkg::S_IDLE && start)
            begin
                uf_q      <= uframe_idx_i;
                pkt_cnt_q <= 2'h0;
                acc_q     <= 3'h0;
            end
            if (st_q == iso_td_pkg::S_ISSUE && more)
            begin
                pkt_cnt_q <= pkt_cnt_q + 2'h1; // RULE7
            end
            if (st_q == iso_td_pkg::S_WAIT && txn_done_i)
            begin
                acc_q[iso_td_pkg::RES_ERR] <= acc_q[iso_td_pkg::RES_ERR] | txn_err_i; // RULE14
                acc_q[iso_td_pkg::RES_BAB] <= acc_q[iso_td_pkg::RES_BAB] | (txn_babble_i & f.token_in); // RULE14
                acc_q[iso_td_pkg::RES_UND] <= acc_q[iso_td_pkg::RES_UND] | (txn_underrun_i & !f.token_in); // RULE14
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transaction request, data held from flip-flops

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            txn_req_o       <= 1'b0;
            txn_split_o     <= 1'b0;
            txn_in_o        <= 1'b0;
            txn_func_addr_o <= 7'h00;
            txn_ep_o        <= 4'h0;
            txn_len_o       <= 11'h000;
            txn_buf_o       <= 16'h0000;
        end
        else if (ce_i)
        begin
            txn_req_o <= (st_q == iso_td_pkg::S_ISSUE) && more; // RULE12
            if (st_q == iso_td_pkg::S_ISSUE && more)
            begin
                txn_split_o     <= f.split;     // RULE2
                txn_in_o        <= f.token_in;  // RULE4
                txn_func_addr_o <= f.func_addr; // RULE5
                txn_ep_o        <= f.ep_num;    // RULE6
                txn_len_o       <= pkt_len;     // RULE8
                txn_buf_o       <= f.buf_start;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Descriptor words; software writes win over hardware clears of its bits

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            dw0_q <= iso_td_pkg::DW_RST;
        end
        else if (ce_i)
        begin
            if ((st_q == iso_td_pkg::S_WAIT && fatal) || (st_q == iso_td_pkg::S_CLOSE && finished))
            begin
                dw0_q[iso_td_pkg::VALID_BIT] <= 1'b0; // RULE10 RULE15
            end
            if (wr0)
            begin
                dw0_q <= wdata_i; // RULE11
            end
            else if (wr3 && wdata_i[iso_td_pkg::ACTIVE_BIT])
            begin
                dw0_q[iso_td_pkg::VALID_BIT] <= 1'b1; // RULE11
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            dw1_q <= iso_td_pkg::DW_RST;
            dw2_q <= iso_td_pkg::DW_RST;
        end
        else if (ce_i)
        begin
            if (wr1)
            begin
                dw1_q <= wdata_i;
            end
            if (wr2)
            begin
                dw2_q <= wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            dw3_q <= iso_td_pkg::DW_RST;
        end
        else if (ce_i)
        begin
            if (wr3)
            begin
                dw3_q <= wdata_i;
            end
            else if (st_q == iso_td_pkg::S_WAIT && txn_done_i && !txn_err_i)
            begin
                dw3_q[iso_td_pkg::DONE_LSB +: iso_td_pkg::XLEN_W] <= 15'(done_bytes + 15'(txn_bytes_i));
            end
            // Halt set wins over a concurrent software write
            if (st_q == iso_td_pkg::S_WAIT && txn_done_i && txn_stall_i)
            begin
                dw3_q[iso_td_pkg::HALT_BIT] <= 1'b1; // RULE15
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            dw4_q <= iso_td_pkg::DW_RST;
        end
        else if (ce_i)
        begin
            if (st_q == iso_td_pkg::S_CLOSE)
            begin
                dw4_q[iso_td_pkg::MASK_LSB + 32'(uf_q)] <= 1'b0; // RULE13
            end
            if (wr4)
            begin
                dw4_q <= wdata_i;
            end
            // Result slot write wins over a concurrent software write of word 4
            if (st_q == iso_td_pkg::S_CLOSE || (st_q == iso_td_pkg::S_WAIT && fatal))
            begin
                dw4_q[iso_td_pkg::RES_LSB + 3 * 32'(uf_q) +: iso_td_pkg::RES_W] <= acc_q | {
                    txn_underrun_i & !f.token_in & fatal, txn_babble_i & f.token_in & fatal,
                    txn_err_i & fatal}; // RULE14
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port: data valid only in the cycle after the strobe

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            rdata_q <= 32'h0000_0000;
            if (re_i)
            begin
                unique case (addr_i)
                    iso_td_pkg::DW0_OFS:  rdata_q <= dw0_q;
                    iso_td_pkg::DW1_OFS:  rdata_q <= dw1_q;
                    iso_td_pkg::DW2_OFS:  rdata_q <= dw2_q;
                    iso_td_pkg::DW3_OFS:  rdata_q <= {dw0_q[iso_td_pkg::VALID_BIT], dw3_q[30:0]};
                    iso_td_pkg::DW4_OFS:  rdata_q <= dw4_q;
                    iso_td_pkg::STAT_OFS: rdata_q <= {20'h00000, st_q, uf_q, acc_q, pkt_cnt_q};
                    default:              rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign rdata_o    = rdata_q;
    assign td_valid_o = dw0_q[iso_td_pkg::VALID_BIT];
    assign td_halt_o  = dw3_q[iso_td_pkg::HALT_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_req_single_pulse: assert property (txn_req_o |=> !txn_req_o) // RULE12
        else $error("request longer than one cycle");
    a_req_only_valid: assert property (txn_req_o |-> $past(dw0_q[iso_td_pkg::VALID_BIT])) // RULE12
        else $error("request issued without valid descriptor");
    a_len_within_max: assert property (txn_req_o |-> txn_len_o <= f.maxp && 15'(txn_len_o) <= f.xfer_len) // RULE8
        else $error("packet length above limit");
    a_token_dir_map: assert property (txn_req_o |-> txn_in_o == f.token_in && txn_split_o == f.split) // RULE4
        else $error("token or split mismatch");
    a_endpoint_assembly: assert property (txn_req_o |->
        txn_ep_o == {dw1_q[2:0], dw0_q[31]} && txn_func_addr_o == dw1_q[9:3]) // RULE6
        else $error("endpoint or address assembled wrongly");
    a_mult_packet_bound: assert property (txn_req_o |-> pkt_cnt_q <= f.mult && pkt_cnt_q != 2'h0) // RULE7
        else $error("more packets than multiplier");
    a_frame_mask_gate: assert property ((st_q == iso_td_pkg::S_IDLE && ce_i) ##1
        (st_q == iso_td_pkg::S_ISSUE) |-> $past(bus_frame_i) == $past(dw2_q[7:3]) && dw4_q[uf_q]) // RULE13
        else $error("microframe started without frame match or mask");
    a_stall_sets_halt: assert property ((st_q == iso_td_pkg::S_WAIT && ce_i && txn_done_i && txn_stall_i
        && !we_i) |=> td_halt_o && !td_valid_o) // RULE15
        else $error("stall did not halt and clear valid");
    a_fatal_clears_valid: assert property ((st_q == iso_td_pkg::S_WAIT && ce_i && txn_done_i && txn_err_i
        && !wr0 && !wr3) |=> !td_valid_o ##1 st_q == iso_td_pkg::S_IDLE) // RULE10
        else $error("fatal error left descriptor valid");
    a_result_slot_write: assert property ((st_q == iso_td_pkg::S_CLOSE && ce_i) |=>
        res_cur == $past(acc_q) && !dw4_q[uf_q]) // RULE14
        else $error("result not written or mask not cleared");

    c_full_microframe: cover property (st_q == iso_td_pkg::S_CLOSE && finished && ce_i);
    c_multi_packet: cover property (txn_req_o && pkt_cnt_q == 2'h3);
    c_stall_halt: cover property (st_q == iso_td_pkg::S_WAIT && txn_done_i && txn_stall_i && ce_i);
endmodule

// ===== src/iso_td_pkg.sv
// Notes on behaviour
// RULE1: Scheduled frame is descriptor byte bits 7..3; bits 2..0 are ignored.
// RULE2: Split bit 0 runs a plain high-speed transaction, 1 a split transaction.
// RULE3: Software writes endpoint kind 01 to mark an isochronous endpoint.
// RULE4: Token field 00 issues OUT, 01 issues IN.
// RULE5: Function address comes from descriptor bits 41..35.
// RULE6: Endpoint number is bits 34..32 on top, bit 31 as LSB.
// RULE7: Multiplier bounds packets issued per execution of the descriptor.
// RULE8: Each packet is limited to the eleven-bit maximum payload size.
// RULE9: Fifteen-bit transfer length is the total byte count of the descriptor.
// RULE10: Valid bit is cleared when the descriptor completes or on fatal error.
// RULE11: Software sets valid when payload waits; the descriptor is then active.
// RULE12: Execute only while valid; split length into packets within maximum payload.
// RULE13: On frame match send only in microframes whose mask bit is set; clear it after.
// RULE14: Per microframe write result: bit0 error, bit1 IN babble, bit2 OUT underrun.
// RULE15: Endpoint stall sets one halted flag and clears valid together.
// RULE16: Software programs buffer start as (processor address - 400h) / 8.
package iso_td_pkg;
    // Register byte offsets
    localparam logic [7:0] DW0_OFS  = 8'h00;
    localparam logic [7:0] DW1_OFS  = 8'h04;
    localparam logic [7:0] DW2_OFS  = 8'h08;
    localparam logic [7:0] DW3_OFS  = 8'h0C;
    localparam logic [7:0] DW4_OFS  = 8'h10;
    localparam logic [7:0] STAT_OFS = 8'h14;
    localparam logic [31:0] DW_RST  = 32'h0000_0000;
    // Word 0 fields
    localparam int VALID_BIT = 0;
    localparam int XLEN_LSB  = 3;
    localparam int XLEN_W    = 15;
    localparam int MAXP_LSB  = 18;
    localparam int MAXP_W    = 11;
    localparam int MULT_LSB  = 29;
    localparam int EP0_BIT   = 31;
    // Word 1 fields
    localparam int EPHI_LSB  = 0;
    localparam int FADDR_LSB = 3;
    localparam int TOKEN_LSB = 10;
    localparam int KIND_LSB  = 12;
    localparam int SPLIT_BIT = 14;
    // Word 2 fields
    localparam int FRAME_LSB = 3;
    localparam int BUF_LSB   = 8;
    // Word 3 fields
    localparam int DONE_LSB   = 0;
    localparam int HALT_BIT   = 30;
    localparam int ACTIVE_BIT = 31;
    // Word 4 fields
    localparam int MASK_LSB = 0;
    localparam int RES_LSB  = 8;
    localparam int RES_W    = 3;
    localparam int RES_ERR  = 0;
    localparam int RES_BAB  = 1;
    localparam int RES_UND  = 2;
    // Encodings
    localparam logic [1:0] KIND_ISO  = 2'h1;
    localparam logic [1:0] TOKEN_OUT = 2'h0;
    localparam logic [1:0] TOKEN_IN  = 2'h1;

    typedef enum logic [3:0] {
        S_IDLE  = 4'h1,
        S_ISSUE = 4'h2,
        S_WAIT  = 4'h4,
        S_CLOSE = 4'h8
    } state_e;
endpackage

// ===== src/td_fields_if.sv
`timescale 1ns/1ps
interface td_fields_if;
    logic [4:0]  frame;
    logic        split;
    logic        kind_iso;
    logic        token_in;
    logic        token_ok;
    logic [6:0]  func_addr;
    logic [3:0]  ep_num;
    logic [1:0]  mult;
    logic [10:0] maxp;
    logic [14:0] xfer_len;
    logic [15:0] buf_start;

    modport dec (output frame, split, kind_iso, token_in, token_ok, func_addr,
                 ep_num, mult, maxp, xfer_len, buf_start);
    modport use_f (input frame, split, kind_iso, token_in, token_ok, func_addr,
                   ep_num, mult, maxp, xfer_len, buf_start);
endinterface

// ===== src/td_field_decode.sv
`timescale 1ns/1ps
module td_field_decode
(
    // Descriptor words
    input  wire logic [31:0] dw0_i,
    input  wire logic [31:0] dw1_i,
    input  wire logic [31:0] dw2_i,
    // Decoded fields
    td_fields_if.dec         f
);
    logic [1:0] token;
    logic [1:0] kind;

    assign token = dw1_i[iso_td_pkg::TOKEN_LSB +: 2];
    assign kind  = dw1_i[iso_td_pkg::KIND_LSB +: 2];

    // Low three bits of the frame byte are don't care
    assign f.frame     = dw2_i[iso_td_pkg::FRAME_LSB +: 5]; // RULE1
    assign f.split     = dw1_i[iso_td_pkg::SPLIT_BIT];      // RULE2
    assign f.kind_iso  = (kind == iso_td_pkg::KIND_ISO);    // RULE3
    assign f.token_in  = (token == iso_td_pkg::TOKEN_IN);   // RULE4
    assign f.token_ok  = (token == iso_td_pkg::TOKEN_IN) || (token == iso_td_pkg::TOKEN_OUT);
    assign f.func_addr = dw1_i[iso_td_pkg::FADDR_LSB +: 7]; // RULE5
    assign f.ep_num    = {dw1_i[iso_td_pkg::EPHI_LSB +: 3], dw0_i[iso_td_pkg::EP0_BIT]}; // RULE6
    assign f.mult      = dw0_i[iso_td_pkg::MULT_LSB +: 2];  // RULE7
    assign f.maxp      = dw0_i[iso_td_pkg::MAXP_LSB +: iso_td_pkg::MAXP_W]; // RULE8
    assign f.xfer_len  = dw0_i[iso_td_pkg::XLEN_LSB +: iso_td_pkg::XLEN_W]; // RULE9
    // Already an internal memory address, taken as written
    assign f.buf_start = dw2_i[iso_td_pkg::BUF_LSB +: 16]; // RULE16
endmodule

// ===== testbench/iso_ep_model.sv
`timescale 1ns/1ps
module iso_ep_model
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Request from the descriptor
    input  wire logic        req_i,
    input  wire logic [10:0] len_i,
    // Behaviour chosen by the bench
    input  wire logic [3:0]  dly_i,
    input  wire logic [3:0]  flags_i,
    // Completion back to the descriptor
    output logic             done_o,
    output logic [10:0]      bytes_o,
    output logic             err_o,
    output logic             babble_o,
    output logic             underrun_o,
    output logic             stall_o
);
    logic [4:0]  cnt_q;
    logic [10:0] len_q;
    logic        busy_q;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            busy_q <= 1'b0;
            cnt_q  <= 5'h00;
            len_q  <= 11'h000;
        end
        else if (req_i)
        begin
            busy_q <= 1'b1;
            cnt_q  <= {1'b0, dly_i};
            len_q  <= len_i;
        end
        else if (busy_q)
        begin
            cnt_q  <= cnt_q - 5'h01;
            busy_q <= (cnt_q != 5'h00);
        end
    end

    // Outside done the lines carry the inverse, so a stray sample shows
    assign done_o     = busy_q && (cnt_q == 5'h00);
    assign bytes_o    = done_o ? len_q : ~len_q;
    assign err_o      = done_o ? flags_i[0] : ~flags_i[0];
    assign babble_o   = done_o ? flags_i[1] : ~flags_i[1];
    assign underrun_o = done_o ? flags_i[2] : ~flags_i[2];
    assign stall_o    = done_o ? flags_i[3] : ~flags_i[3];
endmodule

// ===== testbench/hs_iso_transfer_descriptor_tb.sv
`timescale 1ns/1ps
module hs_iso_transfer_descriptor_tb;
    logic clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, we_i = 1'b0, re_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o;
    logic uframe_tick_i = 1'b0;
    logic [4:0] bus_frame_i = 5'h00;
    logic [2:0] uframe_idx_i = 3'h0;
    logic txn_req_o, txn_split_o, txn_in_o, td_valid_o, td_halt_o;
    logic [6:0] txn_func_addr_o;
    logic [3:0] txn_ep_o, dly = 4'h0, flags = 4'h0;
    logic [10:0] txn_len_o, txn_bytes_i;
    logic [15:0] txn_buf_o;
    logic txn_done_i, txn_err_i, txn_babble_i, txn_underrun_i, txn_stall_i;
    logic [39:0] reqs[$];
    int n_mismatch = 0;
    int n_compared = 0;

    always #12.5 clk_i = ~clk_i;

    hs_iso_transfer_descriptor u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
        .uframe_tick_i(uframe_tick_i), .bus_frame_i(bus_frame_i), .uframe_idx_i(uframe_idx_i),
        .txn_req_o(txn_req_o), .txn_split_o(txn_split_o), .txn_in_o(txn_in_o),
        .txn_func_addr_o(txn_func_addr_o), .txn_ep_o(txn_ep_o), .txn_len_o(txn_len_o),
        .txn_buf_o(txn_buf_o), .txn_done_i(txn_done_i), .txn_bytes_i(txn_bytes_i),
        .txn_err_i(txn_err_i), .txn_babble_i(txn_babble_i), .txn_underrun_i(txn_underrun_i),
        .txn_stall_i(txn_stall_i), .td_valid_o(td_valid_o), .td_halt_o(td_halt_o));

    iso_ep_model u_ep (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(txn_req_o), .len_i(txn_len_o),
        .dly_i(dly), .flags_i(flags), .done_o(txn_done_i), .bytes_o(txn_bytes_i),
        .err_o(txn_err_i), .babble_o(txn_babble_i), .underrun_o(txn_underrun_i),
        .stall_o(txn_stall_i));

    // Requests are logged whole so one compare covers every field
    always @(posedge clk_i)
        if (txn_req_o === 1'b1)
            reqs.push_back({txn_split_o, txn_in_o, txn_func_addr_o, txn_ep_o, txn_len_o, txn_buf_o});

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] w0(logic e, logic [1:0] m, logic [10:0] p, logic [14:0] l);
        return {e, m, p, l, 3'h1};
    endfunction
    function automatic logic [31:0] w1(logic s, logic [1:0] k, logic [1:0] t, logic [6:0] a,
                                       logic [2:0] e);
        return {17'h00000, s, k, t, a, e};
    endfunction

    task automatic check(string what, logic [39:0] seen, logic [39:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk_i);
        we_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        re_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    task automatic rd_check(string what, logic [7:0] a, logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        check(what, d, exp);
    endtask

    // Fresh reset per scenario keeps bytes done from leaking between tests
    task automatic setup(logic [31:0] a0, logic [31:0] a1, logic [31:0] a2, logic [31:0] a4);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        reqs.delete();
        wr(iso_td_pkg::DW1_OFS, a1);
        wr(iso_td_pkg::DW2_OFS, a2);
        wr(iso_td_pkg::DW4_OFS, a4);
        wr(iso_td_pkg::DW0_OFS, a0);
    endtask

    task automatic uframe(logic [2:0] k, int n);
        int i;
        @(posedge clk_i);
        uframe_tick_i <= 1'b1;
        uframe_idx_i  <= k;
        @(posedge clk_i);
        uframe_tick_i <= 1'b0;
        for (i = 0; i < 80 && reqs.size() < n; i++)
            @(posedge clk_i);
        repeat (16) @(posedge clk_i);
        check("request count", reqs.size(), n);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        int i;
        for (i = 0; i < 5; i++)
            rd_check("reset word", 8'(4 * i), 32'h0000_0000);
        rd_check("reset status", iso_td_pkg::STAT_OFS, {20'h00000, iso_td_pkg::S_IDLE, 8'h00});
        check("reset valid", td_valid_o, 1'b0);
        wr(iso_td_pkg::DW3_OFS, 32'h8000_0000);
        rd_check("active sets valid", iso_td_pkg::DW3_OFS, 32'h8000_0000);
        // Enable low must swallow the write strobe
        ce_i <= 1'b0;
        wr(iso_td_pkg::DW0_OFS, 32'h0000_0000);
        ce_i <= 1'b1;
        rd_check("frozen by enable", iso_td_pkg::DW3_OFS, 32'h8000_0000);
        wr(8'h20, 32'hFFFF_FFFF);
        rd_check("unmapped", 8'h20, 32'h0000_0000);
        wr(iso_td_pkg::DW2_OFS, 32'h00AB_CDEF);
        rd_check("word2", iso_td_pkg::DW2_OFS, 32'h00AB_CDEF);
        $display("test regs done");
    endtask

    task automatic t_out();
        logic [15:0] b;
        b = 16'((32'h0001_2400 - 32'h0000_0400) / 8);
        dly <= 4'h0;
        flags <= 4'h0;
        setup(w0(1'b1, 2'h2, 11'h064, 15'h096), w1(1'b1, iso_td_pkg::KIND_ISO, iso_td_pkg::TOKEN_OUT,
              7'h55, 3'h5), {8'h00, b, 5'h0A, 3'h7}, 32'h0000_0004);
        bus_frame_i <= 5'h0B;
        uframe(3'h2, 0);
        bus_frame_i <= 5'h0A;
        uframe(3'h3, 0);
        uframe(3'h2, 2);
        check("packet 0", reqs[0], {1'b1, 1'b0, 7'h55, 4'hB, 11'h064, b});
        check("packet 1", reqs[1], {1'b1, 1'b0, 7'h55, 4'hB, 11'h032, b});
        rd_check("word3", iso_td_pkg::DW3_OFS, 32'h0000_0096);
        rd_check("word4", iso_td_pkg::DW4_OFS, 32'h0000_0000);
        check("valid", td_valid_o, 1'b0);
        $display("test out done");
    endtask

    task automatic t_in();
        dly <= 4'h9;
        flags <= 4'h6;
        setup(w0(1'b0, 2'h1, 11'h0C8, 15'h12C), w1(1'b0, iso_td_pkg::KIND_ISO, iso_td_pkg::TOKEN_IN,
              7'h01, 3'h0), 32'h0000_1018, 32'h0000_0003);
        bus_frame_i <= 5'h03;
        uframe(3'h0, 1);
        check("packet 0", reqs[0], {1'b0, 1'b1, 7'h01, 4'h0, 11'h0C8, 16'h0010});
        rd_check("word4", iso_td_pkg::DW4_OFS, 32'h0000_0202);
        check("valid", td_valid_o, 1'b1);
        flags <= 4'h0;
        uframe(3'h1, 2);
        check("packet 1", reqs[1], {1'b0, 1'b1, 7'h01, 4'h0, 11'h064, 16'h0010});
        rd_check("word4", iso_td_pkg::DW4_OFS, 32'h0000_0200);
        rd_check("word3", iso_td_pkg::DW3_OFS, 32'h0000_012C);
        check("valid", td_valid_o, 1'b0);
        $display("test in done");
    endtask

    task automatic t_fault();
        dly <= 4'h2;
        flags <= 4'h7;
        setup(w0(1'b0, 2'h1, 11'h040, 15'h040), w1(1'b0, iso_td_pkg::KIND_ISO, iso_td_pkg::TOKEN_OUT,
              7'h7F, 3'h7), 32'h0000_00F8, 32'h0000_0080);
        bus_frame_i <= 5'h1F;
        uframe(3'h7, 1);
        check("packet", reqs[0], {1'b0, 1'b0, 7'h7F, 4'hE, 11'h040, 16'h0000});
        rd_check("word4", iso_td_pkg::DW4_OFS, 32'hA000_0000);
        rd_check("word3", iso_td_pkg::DW3_OFS, 32'h0000_0000);
        check("valid", td_valid_o, 1'b0);
        flags <= 4'h8;
        setup(w0(1'b1, 2'h3, 11'h008, 15'h040), w1(1'b0, iso_td_pkg::KIND_ISO, iso_td_pkg::TOKEN_IN,
              7'h2A, 3'h1), 32'h0000_0008, 32'h0000_00FF);
        bus_frame_i <= 5'h01;
        uframe(3'h5, 1);
        check("halt", td_halt_o, 1'b1);
        check("valid", td_valid_o, 1'b0);
        rd_check("word3", iso_td_pkg::DW3_OFS, 32'h4000_0008);
        $display("test fault done");
    endtask

    task automatic t_bad();
        logic [31:0] a0[3];
        logic [31:0] a1[3];
        int i;
        // Multiplier 1, so a wrongly accepted descriptor would show a request
        a0 = '{32'h2010_0040, 32'h2010_0041, 32'h2010_0041};
        a1 = '{w1(1'b0, 2'h1, 2'h0, 7'h03, 3'h0), w1(1'b0, 2'h1, 2'h2, 7'h03, 3'h0),
               w1(1'b0, 2'h2, 2'h0, 7'h03, 3'h0)};
        for (i = 0; i < 3; i++)
        begin
            setup(a0[i], a1[i], 32'h0000_0000, 32'h0000_0001);
            bus_frame_i <= 5'h00;
            uframe(3'h0, 0);
            check("valid kept", td_valid_o, a0[i][0]);
        end
        $display("test bad done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_out();
        t_in();
        t_fault();
        t_bad();
        stop_test();
    end

    // More than thirty times the expected run length
    initial
    begin
        repeat (12000) @(posedge clk_i);
        n_mismatch++;
        stop_test();
    end
endmodule
